//--- logic/rlm_monitor.sv
// radiation limit monitor: threshold, hysteresis, delays, send policy
// assumes sample, bus object and register strobes all on mclk
//
// Summary of operation
// - internal level 300 to 1300 in 100 steps
// - hysteresis none, 0.3, 0.5, 1, 3, 5
// - upper mode: exceed sets, below level-hyst resets
// - lower mode: below sets, above level+hyst resets
// - twelve modes, one direction may send nothing
// - external level by word or byte object
// - teach object stores current sample as level
// - download drops external level until fresh value
// - rise to one waits full switch-on delay
// - cyclic sends old zero during on delay
// - fall to zero waits full switch-off delay
// - cyclic sends old one during off delay
// - no-telegram condition also stops cyclic sends
// - send-on-change sends every accepted change
// - cyclic period is setting times ten seconds
// - nonzero setting sends periodically unless no-telegram
// - no change send and zero period: silent
// - output is one-bit limit state object
// - byte level is percent of range top
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module rlm_monitor
  import rlm_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
)
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // sensor samples
  input  wire logic [15:0] meas_value,
  input  wire logic        meas_valid,
  // incoming bus objects
  input  wire logic [15:0] ext_word,
  input  wire logic        ext_word_wr,
  input  wire logic [7:0]  ext_pct,
  input  wire logic        ext_pct_wr,
  input  wire logic        teach_wr,
  // limit output object
  output logic             limit_state,
  output logic             limit_send,
  output logic             limit_send_val
);

  // ****************************************
  // configuration registers
  // ****************************************
  logic [13:0] ctrl_reg;
  logic [7:0]  dly_reg;
  logic [6:0]  cyc_reg;
  logic [15:0] rdata_reg;

  wire wr_ctrl = reg_wr && (reg_addr == A_CTRL);
  wire wr_dly  = reg_wr && (reg_addr == A_DLY);
  wire wr_cyc  = reg_wr && (reg_addr == A_CYC);

  // software writes, frozen by clock enable
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_reg <= CTRL_RST;
      dly_reg  <= DLY_RST;
      cyc_reg  <= CYC_RST;
    end
    else if (clk_en)
    begin
      if (wr_ctrl)
        ctrl_reg <= reg_wdata[13:0];
      if (wr_dly)
        dly_reg <= reg_wdata[7:0];
      if (wr_cyc)
        cyc_reg <= reg_wdata[6:0];
    end
  end

  // ****************************************
  // field decode
  // ****************************************
  wire [3:0]  lvl_sel  = ctrl_reg[CT_LVL +: 4];
  wire [2:0]  hys_sel  = ctrl_reg[CT_HYS +: 3];
  wire [3:0]  mode_sel = ctrl_reg[CT_MODE +: 4];
  wire [1:0]  ext_sel  = ctrl_reg[CT_EXT +: 2];
  wire        soc_en   = ctrl_reg[CT_SOC];
  wire [4:0]  mode_w   = mode_dec(mode_sel);
  wire        lower    = mode_w[4];
  wire [1:0]  p_act    = mode_w[3:2];
  wire [1:0]  s_act    = mode_w[1:0];
  wire [15:0] hyst     = hys_x10(hys_sel);
  wire [15:0] lvl_cfg  = lvl_x10(lvl_sel);
  wire        cyc_on   = (cyc_reg != 7'h00);

  // ****************************************
  // sample and external level
  // ****************************************
  logic [15:0] meas_reg;
  logic [15:0] ext_lvl_reg;
  logic        ext_ok_reg;

  // percent of range top, clamped at full scale
  wire [7:0]  pct_c  = (ext_pct > 8'(PCT_FULL)) ? 8'(PCT_FULL) : ext_pct;
  wire [15:0] pct_lv = 16'(32'(pct_c) * PCT_STEP_X10);

  wire take_word  = ext_word_wr && (ext_sel == EXT_WORD);
  wire take_pct   = ext_pct_wr && (ext_sel == EXT_PCT);
  wire take_teach = teach_wr && (ext_sel == EXT_TEACH);
  wire ext_set    = take_word || take_pct || take_teach;

  // external value overrides only once a fresh one arrived
  wire use_ext = (ext_sel != EXT_NONE) && ext_ok_reg;
  wire [15:0] lvl_act = use_ext ? ext_lvl_reg : lvl_cfg;

  // latest sample
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      meas_reg <= 16'h0000;
    else if (clk_en && meas_valid)
      meas_reg <= meas_value;
  end

  // external level store; a fresh value wins over a download
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_lvl_reg <= 16'h0000;
      ext_ok_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (take_word)
        ext_lvl_reg <= ext_word;
      else if (take_pct)
        ext_lvl_reg <= pct_lv;
      else if (take_teach)
        ext_lvl_reg <= meas_reg;
      if (ext_set)
        ext_ok_reg <= 1'b1;
      else if (wr_ctrl)
        ext_ok_reg <= 1'b0;
    end
  end

  // ****************************************
  // threshold with hysteresis
  // ****************************************
  logic cond_reg;

  wire [16:0] m17    = {1'b0, meas_value};
  wire [16:0] lv17   = {1'b0, lvl_act};
  wire [16:0] h17    = {1'b0, hyst};
  wire up_set  = m17 > lv17;
  wire up_clr  = (m17 + h17) < lv17;
  wire lo_set  = m17 < lv17;
  wire lo_clr  = m17 > (lv17 + h17);
  wire c_set   = lower ? lo_set : up_set;
  wire c_clr   = lower ? lo_clr : up_clr;

  // primary condition: exceeded (upper) or undershot (lower)
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      cond_reg <= 1'b0;
    else if (clk_en && meas_valid)
    begin
      if (c_set)
        cond_reg <= 1'b1;
      else if (c_clr)
        cond_reg <= 1'b0;
    end
  end

  // ****************************************
  // action and delay
  // ****************************************
  logic obj_reg;

  wire [1:0]  act_now = cond_reg ? p_act : s_act;
  wire        act_snd = (act_now != ACT_NONE);
  wire        tgt     = (act_now == ACT_ON);
  wire        pend    = act_snd && (tgt != obj_reg);
  wire [3:0]  d_sel   = tgt ? dly_reg[DL_ON +: 4] : dly_reg[DL_OFF +: 4];
  wire [11:0] d_secs  = dly_sec(d_sel);
  wire        d_zero  = (d_secs == 12'h000);
  wire        d_busy;
  wire        d_done;
  wire        d_start = pend && !d_zero && !d_busy && !d_done;
  wire        d_stop  = !pend;
  wire        accept  = pend && (d_zero || d_done);

  // delay timer; withdrawn change cancels it
  rlm_sec_timer #(
    .TICKS (TICKS)
  ) u_dly (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .clk_en (clk_en),
    .start  (d_start),
    .stop   (d_stop),
    .secs   (d_secs),
    .busy   (d_busy),
    .done   (d_done)
  );

  // accepted limit state, zero after reset
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      obj_reg <= 1'b0;
    else if (clk_en && accept)
      obj_reg <= tgt;
  end

  // ****************************************
  // send policy
  // ****************************************
  logic        send_reg;
  logic        sval_reg;
  wire         c_busy;
  wire         c_done;
  wire [11:0]  c_secs  = 12'(32'(cyc_reg) * CYC_UNIT_S);
  wire         c_start = cyc_on && !c_busy;
  wire         c_stop  = !cyc_on;
  wire         chg_snd = soc_en && accept;
  wire         cyc_snd = c_done && cyc_on && act_snd;

  // free-running repeat timer
  rlm_sec_timer #(
    .TICKS (TICKS)
  ) u_cyc (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .clk_en (clk_en),
    .start  (c_start),
    .stop   (c_stop),
    .secs   (c_secs),
    .busy   (c_busy),
    .done   (c_done)
  );

  // one send pulse; cyclic carries the held state
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      send_reg <= 1'b0;
      sval_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      send_reg <= chg_snd || cyc_snd;
      sval_reg <= accept ? tgt : obj_reg;
    end
  end

  assign limit_state    = obj_reg;
  assign limit_send     = send_reg;
  assign limit_send_val = sval_reg;

  // ****************************************
  // register read
  // ****************************************
  wire [15:0] stat_w = {11'h000, c_busy, d_busy, ext_ok_reg,
                        cond_reg, obj_reg};
  wire [15:0] rd_mux =
    (reg_addr == A_CTRL)  ? {2'b00, ctrl_reg} :
    (reg_addr == A_DLY)   ? {8'h00, dly_reg} :
    (reg_addr == A_CYC)   ? {9'h000, cyc_reg} :
    (reg_addr == A_STAT)  ? stat_w :
    (reg_addr == A_LEVEL) ? lvl_act : 16'h0000;

  // read data valid the cycle after the strobe only
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_reg <= 16'h0000;
    else if (clk_en)
      rdata_reg <= reg_rd ? rd_mux : 16'h0000;
  end

  assign reg_rdata = rdata_reg;

  // ****************************************
  // checks
  // ****************************************
  chk_upper_set: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (clk_en && meas_valid && !lower && up_set) |=> cond_reg)
    else $error("upper crossing not latched");

  chk_lower_set: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (clk_en && meas_valid && lower && lo_set) |=> cond_reg)
    else $error("lower crossing not latched");

  chk_rise_delay: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ($rose(obj_reg) && ($past(d_secs) != 12'h000)) |-> $past(d_done))
    else $error("output rose before switch-on delay");

  chk_fall_delay: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ($fell(obj_reg) && ($past(d_secs) != 12'h000)) |-> $past(d_done))
    else $error("output fell before switch-off delay");

  chk_held_value: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (send_reg && !$past(accept)) |-> (sval_reg == obj_reg))
    else $error("cyclic send not carrying held state");

  chk_no_tele: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (clk_en && !act_snd) |=> !send_reg)
    else $error("send during no-telegram condition");

  chk_change_send: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (clk_en && soc_en && accept) |=> (send_reg && sval_reg == obj_reg))
    else $error("accepted change not sent");

  chk_silent_cfg: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (clk_en && !soc_en && !cyc_on) |=> !send_reg)
    else $error("send while all sending disabled");

  chk_teach_store: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (clk_en && take_teach) |=>
      (ext_ok_reg && ext_lvl_reg == $past(meas_reg)))
    else $error("teach did not store sample");

  chk_download_drop: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (clk_en && wr_ctrl && !ext_set) |=> !ext_ok_reg)
    else $error("external level kept after download");

endmodule

//--- logic/rlm_pkg.sv
// radiation limit monitor: shared constants, field layout, tables
// assumes a 40 MHz system clock and 16-bit samples in 0.1 W/m2
package rlm_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ      = 40_000_000;
  localparam int TICK_S      = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;
  localparam int CYC_UNIT_S  = 10;

  // ****************************************
  // scaling of levels (all levels in 0.1 W/m2)
  // ****************************************
  localparam int LVL_SCALE     = 10;
  localparam int LVL_BASE_W    = 300;
  localparam int LVL_STEP_W    = 100;
  localparam int LVL_SEL_MAX   = 10;
  localparam int RANGE_TOP_W   = 2000;
  localparam int PCT_FULL      = 100;
  localparam int PCT_STEP_X10  = RANGE_TOP_W * LVL_SCALE / PCT_FULL;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [3:0] A_CTRL  = 4'h0;
  localparam logic [3:0] A_DLY   = 4'h1;
  localparam logic [3:0] A_CYC   = 4'h2;
  localparam logic [3:0] A_STAT  = 4'h3;
  localparam logic [3:0] A_LEVEL = 4'h4;
  localparam int CT_LVL  = 0;
  localparam int CT_HYS  = 4;
  localparam int CT_MODE = 7;
  localparam int CT_EXT  = 11;
  localparam int CT_SOC  = 13;
  localparam int DL_ON   = 0;
  localparam int DL_OFF  = 4;
  localparam logic [13:0] CTRL_RST = 14'h0000;
  localparam logic [7:0]  DLY_RST  = 8'h00;
  localparam logic [6:0]  CYC_RST  = 7'h00;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_OFF  = 2'b10,
    ACT_ON   = 2'b11
  } rlm_act_t;

  typedef enum logic [1:0] {
    EXT_NONE  = 2'b00,
    EXT_WORD  = 2'b01,
    EXT_PCT   = 2'b10,
    EXT_TEACH = 2'b11
  } rlm_ext_t;

  // ****************************************
  // lookup functions
  // ****************************************
  function automatic logic [15:0] lvl_x10(input logic [3:0] sel);
    int s;
    s = (int'(sel) > LVL_SEL_MAX) ? LVL_SEL_MAX : int'(sel);
    return 16'((LVL_BASE_W + s * LVL_STEP_W) * LVL_SCALE);
  endfunction

  // hysteresis in tenths of a unit: none,0.3,0.5,1,3,5
  function automatic logic [15:0] hys_x10(input logic [2:0] sel);
    unique case (sel)
      3'h0: return 16'h0000;
      3'h1: return 16'h0003;
      3'h2: return 16'h0005;
      3'h3: return 16'h000a;
      3'h4: return 16'h001e;
      default: return 16'h0032;
    endcase
  endfunction

  // delay in seconds: none,1,3,5,10,15,30 s,1,3,5,10,15,30,60 min
  function automatic logic [11:0] dly_sec(input logic [3:0] sel);
    unique case (sel)
      4'h0: return 12'h000;
      4'h1: return 12'h001;
      4'h2: return 12'h003;
      4'h3: return 12'h005;
      4'h4: return 12'h00a;
      4'h5: return 12'h00f;
      4'h6: return 12'h01e;
      4'h7: return 12'h03c;
      4'h8: return 12'h0b4;
      4'h9: return 12'h12c;
      4'ha: return 12'h258;
      4'hb: return 12'h384;
      4'hc: return 12'h708;
      default: return 12'he10;
    endcase
  endfunction

  // mode -> {lower, primary action, secondary action}
  function automatic logic [4:0] mode_dec(input logic [3:0] m);
    unique case (m)
      4'h0: return {1'b0, ACT_ON,   ACT_OFF};
      4'h1: return {1'b0, ACT_OFF,  ACT_ON};
      4'h2: return {1'b1, ACT_ON,   ACT_OFF};
      4'h3: return {1'b1, ACT_OFF,  ACT_ON};
      4'h4: return {1'b0, ACT_ON,   ACT_NONE};
      4'h5: return {1'b0, ACT_OFF,  ACT_NONE};
      4'h6: return {1'b1, ACT_ON,   ACT_NONE};
      4'h7: return {1'b1, ACT_OFF,  ACT_NONE};
      4'h8: return {1'b0, ACT_NONE, ACT_OFF};
      4'h9: return {1'b0, ACT_NONE, ACT_ON};
      4'ha: return {1'b1, ACT_NONE, ACT_OFF};
      4'hb: return {1'b1, ACT_NONE, ACT_ON};
      default: return {1'b0, ACT_ON, ACT_OFF};
    endcase
  endfunction

endpackage

//--- logic/rlm_sec_timer.sv
// radiation limit monitor: seconds timer with its own prescaler
// assumes start and stop from logic on mclk
`timescale 1ns/10ps
module rlm_sec_timer
  import rlm_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
)
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // control
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [11:0] secs,
  // status
  output logic             busy,
  output logic             done
);

  logic [25:0] pre_reg;
  logic [11:0] sec_reg;
  logic        busy_reg;
  logic        done_reg;
  wire         sec_end = (pre_reg == 26'(TICKS - 1));
  wire         last    = sec_end && (sec_reg == 12'h001);

  // prescaler restarts on start so a full delay always elapses
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pre_reg  <= 26'h0000000;
      sec_reg  <= 12'h000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      done_reg <= busy_reg && !stop && !start && last;
      if (stop)
      begin
        busy_reg <= 1'b0;
      end
      else if (start)
      begin
        pre_reg  <= 26'h0000000;
        sec_reg  <= secs;
        busy_reg <= (secs != 12'h000);
      end
      else if (busy_reg)
      begin
        pre_reg <= sec_end ? 26'h0000000 : pre_reg + 26'h0000001;
        if (sec_end)
        begin
          sec_reg <= sec_reg - 12'h001;
        end
        if (last)
        begin
          busy_reg <= 1'b0;
        end
      end
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;

endmodule

//--- bench/rlm_bus_model.sv
// field bus partner: sends external level and teach objects
// assumes tasks are called from the bench sequence on mclk
`timescale 1ns/10ps
module rlm_bus_model
(
  // clock
  input  wire logic        mclk,
  // objects towards the monitor
  output logic      [15:0] ext_word,
  output logic             ext_word_wr,
  output logic      [7:0]  ext_pct,
  output logic             ext_pct_wr,
  output logic             teach_wr
);
  // idle lines at time zero
  initial
  begin
    ext_word    = 16'h0000;
    ext_word_wr = 1'b0;
    ext_pct     = 8'h00;
    ext_pct_wr  = 1'b0;
    teach_wr    = 1'b0;
  end

  // one object per call; released data lines show the inverse
  task automatic send(input logic [1:0] k, input logic [15:0] v);
    @(posedge mclk);
    ext_word    <= v;
    ext_pct     <= v[7:0];
    ext_word_wr <= (k == 2'h1);
    ext_pct_wr  <= (k == 2'h2);
    teach_wr    <= (k == 2'h3);
    @(posedge mclk);
    ext_word    <= ~v;
    ext_pct     <= ~v[7:0];
    ext_word_wr <= 1'b0;
    ext_pct_wr  <= 1'b0;
    teach_wr    <= 1'b0;
  endtask
endmodule

//--- bench/tb.sv
// self-checking bench for the radiation limit monitor
// assumes rlm_pkg and rlm_bus_model are compiled first
`timescale 1ns/10ps
module tb;
  import rlm_pkg::*;
  localparam int TK = 4;
  logic        mclk, rst_b, clk_en, reg_wr, reg_rd, meas_valid;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, meas_value, ext_word, cw, x;
  logic [7:0]  ext_pct;
  logic        ext_word_wr, ext_pct_wr, teach_wr;
  logic        limit_state, limit_send, limit_send_val, cnd, st;
  logic        rd_d = 1'b0;
  logic [15:0] rd_q[$];
  logic        tel_q[$];
  int          mismatches, n_tests;
  int          hy[8] = '{0, 3, 5, 10, 30, 50, 50, 50};
  logic [3:0]  ad[5] = '{A_CTRL, A_DLY, A_CYC, A_STAT, 4'hf};

  rlm_monitor #(.TICKS(TK)) i_rlm_monitor (.mclk(mclk), .rst_b(rst_b),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .meas_value(meas_value), .meas_valid(meas_valid),
    .ext_word(ext_word), .ext_word_wr(ext_word_wr), .ext_pct(ext_pct),
    .ext_pct_wr(ext_pct_wr), .teach_wr(teach_wr),
    .limit_state(limit_state), .limit_send(limit_send),
    .limit_send_val(limit_send_val));
  rlm_bus_model i_rlm_bus_model (.mclk(mclk), .ext_word(ext_word),
    .ext_word_wr(ext_word_wr), .ext_pct(ext_pct),
    .ext_pct_wr(ext_pct_wr), .teach_wr(teach_wr));

  // ****************************************
  // clock, compare and report
  // ****************************************
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watcher: read data one cycle after the strobe, telegrams in order
  always @(posedge mclk)
  begin
    if (rd_d)
      chk("reg_rdata", reg_rdata, rd_q.pop_front());
    if (limit_send === 1'b1)
      if (tel_q.size() == 0)
        chk("limit_send", 16'h0001, 16'h0000);
      else
        chk("limit_send_val", 16'(limit_send_val), 16'(tel_q.pop_front()));
    rd_d <= reg_rd;
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    results();
  end

  // ****************************************
  // bus, sample and expectation tasks
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rd_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask

  // expected state from mode table and condition
  task automatic settle();
    logic [3:0] m;
    logic       nn;
    logic       v;
    m  = cw[10:7];
    nn = cnd ? (m >= 4'h8) : (m[3:2] == 2'b01);
    v  = cnd ? ~m[0] : m[0];
    if (!nn && v !== st)
    begin
      st = v;
      if (cw[13])
        tel_q.push_back(v);
    end
  endtask

  task automatic wc(input logic [15:0] w);
    cw = w;
    settle();
    wr(A_CTRL, w);
    repeat (4) @(posedge mclk);
  endtask

  task automatic smp(input logic [15:0] v);
    int lv;
    int h;
    lv = (300 + 100 * ((cw[3:0] > 10) ? 10 : cw[3:0])) * 10;
    h  = hy[cw[6:4]];
    if (clk_en && (cw[8] ? v < lv : v > lv))
      cnd = 1'b1;
    else if (clk_en && (cw[8] ? v > lv + h : v + h < lv))
      cnd = 1'b0;
    if (clk_en)
      settle();
    @(posedge mclk);
    meas_value <= v;
    meas_valid <= 1'b1;
    @(posedge mclk);
    meas_valid <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask

  task automatic sc(input logic [15:0] v);
    smp(v);
    chk("limit_state", 16'(limit_state), 16'(st));
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    meas_value = 16'h0000;
    meas_valid = 1'b0;
    cw = 16'h0000;
    cnd = 1'b0;
    st = 1'b0;
    mismatches = 0;
    n_tests = 0;
    void'($urandom(99));
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    chk("limit_state", 16'(limit_state), 16'h0000);
    foreach (ad[i])
      rd(ad[i], 16'h0000);
    wr(A_STAT, 16'hffff);
    rd(A_STAT, 16'h0000);
    for (int s = 0; s < 12; s++)
    begin
      wc(16'(s));
      rd(A_LEVEL, 16'((300 + 100 * ((s > 10) ? 10 : s)) * 10));
    end
    // hysteresis edges, upper then lower
    for (int k = 0; k < 12; k++)
    begin
      wc({3'b001, 2'b00, ((k > 5) ? 4'h2 : 4'h0), 3'(k % 6), 4'h0});
      sc(16'(3000 + ((k > 5) ? -1 : 1)));
      sc(16'(3000 - ((k > 5) ? -1 : 1) * hy[k % 6]));
      sc(16'(3000 - ((k > 5) ? -1 : 1) * (hy[k % 6] + 1)));
    end
    for (int m = 0; m < 12; m++)
    begin
      wc({3'b001, 2'b00, 4'(m), 7'h00});
      sc(16'd4000);
      sc(16'd2000);
    end
    // frozen clock enable drops the sample
    clk_en <= 1'b0;
    @(posedge mclk);
    smp(16'd4000);
    clk_en <= 1'b1;
    chk("limit_state", 16'(limit_state), 16'(st));
    // long delays with cyclic repeats carrying the old value
    wc(16'h0000);
    smp(16'd2000);
    for (int d = 0; d < 2; d++)
    begin
      wr(A_DLY, d ? 16'h0070 : 16'h0007);
      wr(A_CYC, 16'h0001);
      tel_q.push_back(d[0]);
      tel_q.push_back(d[0]);
      smp(d ? 16'd2000 : 16'd4000);
      repeat (90) @(posedge mclk);
      // both timers running, condition already moved, state held
      rd(A_STAT, d ? 16'h0019 : 16'h001a);
      wr(A_CYC, 16'h0000);
      chk("limit_state", 16'(limit_state), 16'(d));
      repeat (160) @(posedge mclk);
      chk("limit_state", 16'(limit_state), 16'(1 - d));
    end
    // no-telegram action also silences cyclic sends
    wr(A_DLY, 16'h0000);
    wc({3'b001, 2'b00, 4'h8, 7'h00});
    smp(16'd4000);
    wr(A_CYC, 16'h0001);
    repeat (100) @(posedge mclk);
    wr(A_CYC, 16'h0000);
    // external level objects and download
    x = 16'($urandom_range(1000, 20000));
    wc(16'h0800);
    i_rlm_bus_model.send(2'h1, x);
    rd(A_LEVEL, x);
    wc(16'h0800);
    rd(A_LEVEL, 16'd3000);
    wc(16'h1000);
    i_rlm_bus_model.send(2'h1, x);
    rd(A_LEVEL, 16'd3000);
    i_rlm_bus_model.send(2'h2, 16'd37);
    rd(A_LEVEL, 16'd7400);
    i_rlm_bus_model.send(2'h2, 16'd150);
    rd(A_LEVEL, 16'd20000);
    wc(16'h1800);
    sc(x);
    i_rlm_bus_model.send(2'h3, 16'h0000);
    rd(A_LEVEL, x);
    for (int i = 0; i < 100 && tel_q.size() + rd_q.size() > 0; i++)
      @(posedge mclk);
    if (tel_q.size() + rd_q.size() > 0)
      mismatches++;
    results();
  end
endmodule
